// File: pll_seq_pkg.sv
// package: constants for the pll reset and init sequencing controller
//
// Summary of operation
// RULE_01: page 0x10 offset 0x49 bit 4 holds video-input pll fsm in reset.
// RULE_02: page 0x14 offset 0x49 bit 4 holds serial-link pll fsm in reset.
// RULE_03: writes to paged pll reset registers keep low four bits zero.
// RULE_04: first init clears bit 5 of address 0x5B.
// RULE_05: first init writes 0x02 to address 0x16.
// RULE_06: first init sets bit 4 of address 0x04.
// RULE_07: pll resets start only after the tmds clock is stable.
// RULE_08: video pll reset: 0x10->0x40, 0x49->0x41, 0x10->0x42, 0x00->0x42.
// RULE_09: then link pll reset: 0x14->0x40, 0x49->0x41, 0x10->0x42, 0x00->0x42.
// RULE_10: supplies, settle, raise power-down pin, then allow video input.
// RULE_11: no device input is driven before supplies are steady.
// RULE_12: power-down pin is active low, driven by this controller.
// RULE_13: paged registers reached via page 0x40, offset 0x41, data 0x42.
// RULE_14: wait at least 2 ms after pin rises before bus access.
// RULE_15: hard reset holds the power-down pin low at least 2 ms.
// RULE_16: tmds clock stable within 0.5 percent for at least 1 us first.
// RULE_17: first init, user config included, finishes before pll resets; the pll start waits for first init only, not for user writes.
package pll_seq_pkg;
   localparam int CLK_MHZ          = 125;
   localparam int T_BUS_READY_MS   = 2;
   localparam int T_HARD_RESET_MS  = 2;
   localparam int T_CLK_STABLE_US  = 1;
   localparam int BUS_READY_CYC    = T_BUS_READY_MS * 1000 * CLK_MHZ;
   localparam int HARD_RESET_CYC   = T_HARD_RESET_MS * 1000 * CLK_MHZ;
   localparam int CLK_STABLE_CYC   = T_CLK_STABLE_US * CLK_MHZ;

   // device configuration-bus addresses and values
   localparam logic [7:0] DEV_PAGE_SEL   = 8'h40;
   localparam logic [7:0] DEV_PAGE_OFS   = 8'h41;
   localparam logic [7:0] DEV_PAGE_DATA  = 8'h42;
   localparam logic [7:0] PAGE_VIDEO_PLL = 8'h10;
   localparam logic [7:0] PAGE_LINK_PLL  = 8'h14;
   localparam logic [7:0] PLL_CTRL_OFS   = 8'h49;
   localparam int         PLL_RESET_BIT  = 4;
   localparam logic [7:0] PLL_CTRL_RESET = 8'h00;
   localparam logic [7:0] PLL_CTRL_RSV   = 8'h0F;
   localparam logic [7:0] PLL_ASSERT     = 8'h10;
   localparam logic [7:0] PLL_RELEASE    = 8'h00;
   localparam logic [7:0] FREQ_RST_ADDR  = 8'h5B;
   localparam int         FREQ_RST_BIT   = 5;
   localparam logic [7:0] GLITCH_ADDR    = 8'h16;
   localparam logic [7:0] GLITCH_VAL     = 8'h02;
   localparam logic [7:0] BLANK_ADDR     = 8'h04;
   localparam int         BLANK_BIT      = 4;

   // controller registers on apb (byte addresses)
   localparam logic [11:0] REG_CTRL    = 12'h000;
   localparam logic [11:0] REG_STATUS  = 12'h004;
   localparam logic [11:0] REG_USER    = 12'h008;
   localparam logic [11:0] REG_RDDATA  = 12'h00C;
   localparam int CTRL_START      = 0;
   localparam int CTRL_PLL_GO     = 1;
   localparam int CTRL_HARD_RESET = 2;
   localparam int CTRL_USER_WR    = 3;
   localparam int CTRL_USER_RD    = 4;
   localparam int ST_BUSY         = 0;
   localparam int ST_INIT_DONE    = 1;
   localparam int ST_PLL_DONE     = 2;
   localparam int ST_PIN          = 3;
   localparam int ST_BUS_ERR      = 4;
   localparam int ST_CLK_OK       = 5;
   localparam int ST_VIDEO_EN     = 6;

   typedef enum logic [1:0] {
      OP_WRITE,
      OP_READ,
      OP_RMW_SET,
      OP_RMW_CLR
   } op_e;
endpackage

// File: pll_reset_init_sequencer.sv
// module: host-side power-up, init and pll reset sequencer
`timescale 1ns/1ns
module pll_reset_init_sequencer #(
   parameter int BUS_READY_CYC  = pll_seq_pkg::BUS_READY_CYC,
   parameter int HARD_RESET_CYC = pll_seq_pkg::HARD_RESET_CYC,
   parameter int CLK_STABLE_CYC = pll_seq_pkg::CLK_STABLE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        supplies_good,
   input  wire logic        tmds_clk_ok,
   output logic             power_down_bar_pin,
   output logic             video_input_enable,
   output logic             cfg_req,
   output logic             cfg_write,
   output logic [7:0]       cfg_addr,
   output logic [7:0]       cfg_wdata,
   input  wire logic        cfg_ack,
   input  wire logic        cfg_err,
   input  wire logic [7:0]  cfg_rdata
);
   initial begin
      if (BUS_READY_CYC < 1 || HARD_RESET_CYC < 1 || CLK_STABLE_CYC < 1)
         $error("sequencer counts must be at least one");
   end

   typedef enum {
      S_OFF, S_PIN_LOW, S_BUS_WAIT, S_IDLE,
      S_FR_RD, S_FR_WR, S_GL_WR, S_BK_RD, S_BK_WR,
      S_CLK_WAIT, S_PLL_STEP, S_USER, S_ERR
   } state_e;

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] sup_sync_r;
   logic [1:0] tmds_sync_r;
   logic       sup_ok;
   logic       tmds_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_sync_r  <= 2'h0;
         tmds_sync_r <= 2'h0;
      end else begin
         sup_sync_r  <= {sup_sync_r[0], supplies_good};
         tmds_sync_r <= {tmds_sync_r[0], tmds_clk_ok};
      end
   end
   assign sup_ok  = sup_sync_r[1];
   assign tmds_ok = tmds_sync_r[1];

   // ------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------
   state_e      st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [2:0]  step_r, step_nxt;
   logic        req_r, req_nxt;
   logic        wr_r, wr_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic [7:0]  wdata_r, wdata_nxt;
   logic [7:0]  rd_r, rd_nxt;
   logic        pin_r, pin_nxt;
   logic        vid_r, vid_nxt;
   logic        init_done_r, init_done_nxt;
   logic        pll_done_r, pll_done_nxt;
   logic        err_r, err_nxt;
   logic        clk_seen_r, clk_seen_nxt;
   logic [15:0] user_r, user_nxt;
   logic        start_p, pll_go_p, hard_p, uwr_p, urd_p;

   // one paged pll write in sequence; data-port writes keep low nibble zero
   function automatic logic [15:0] pll_step(input logic [2:0] s);
      logic [7:0] page;
      page = s[2] ? pll_seq_pkg::PAGE_LINK_PLL
                  : pll_seq_pkg::PAGE_VIDEO_PLL;          // [RULE_09]
      unique case (s[1:0])
         2'd0: pll_step = {pll_seq_pkg::DEV_PAGE_SEL, page};   // [RULE_13]
         2'd1: pll_step = {pll_seq_pkg::DEV_PAGE_OFS,
                           pll_seq_pkg::PLL_CTRL_OFS};
         2'd2: pll_step = {pll_seq_pkg::DEV_PAGE_DATA,
                           pll_seq_pkg::PLL_ASSERT &
                           ~pll_seq_pkg::PLL_CTRL_RSV};   // [RULE_01] [RULE_03]
         default: pll_step = {pll_seq_pkg::DEV_PAGE_DATA,
                           pll_seq_pkg::PLL_RELEASE &
                           ~pll_seq_pkg::PLL_CTRL_RSV};   // [RULE_02] [RULE_03]
      endcase
   endfunction

   task automatic issue(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
      req_nxt   = 1'b1;
      wr_nxt    = w;
      addr_nxt  = a;
      wdata_nxt = d;
   endtask

   // a call result cannot be part-selected, so the steps are held as nets
   logic [15:0] op_first;
   logic [15:0] op_next;
   assign op_first = pll_step(3'd0);
   assign op_next  = pll_step(step_r + 3'd1);

   always_comb begin
      st_nxt        = st_r;
      cnt_nxt       = cnt_r;
      step_nxt      = step_r;
      req_nxt       = req_r;
      wr_nxt        = wr_r;
      addr_nxt      = addr_r;
      wdata_nxt     = wdata_r;
      rd_nxt        = rd_r;
      pin_nxt       = pin_r;
      vid_nxt       = vid_r;
      init_done_nxt = init_done_r;
      pll_done_nxt  = pll_done_r;
      err_nxt       = err_r;
      clk_seen_nxt  = clk_seen_r;
      if (req_r && cfg_ack) begin
         req_nxt = 1'b0;
         rd_nxt  = cfg_rdata;
         if (cfg_err)
            err_nxt = 1'b1;
      end
      if (hard_p && st_r != S_OFF) begin
         pin_nxt      = 1'b0;                              // [RULE_15]
         vid_nxt      = 1'b0;
         req_nxt      = 1'b0;
         cnt_nxt      = 32'h0;
         init_done_nxt = 1'b0;
         pll_done_nxt = 1'b0;
         st_nxt       = S_PIN_LOW;
      end else begin
         unique case (st_r)
            S_OFF: begin
               if (sup_ok) begin                           // [RULE_10] [RULE_11]
                  pin_nxt = 1'b1;                          // [RULE_12]
                  cnt_nxt = 32'h0;
                  st_nxt  = S_BUS_WAIT;
               end
            end
            S_PIN_LOW: begin
               cnt_nxt = cnt_r + 32'h1;
               if (cnt_r >= 32'(HARD_RESET_CYC - 1) && sup_ok) begin // [RULE_15]
                  pin_nxt = 1'b1;
                  cnt_nxt = 32'h0;
                  st_nxt  = S_BUS_WAIT;
               end
            end
            S_BUS_WAIT: begin
               cnt_nxt = cnt_r + 32'h1;
               if (cnt_r >= 32'(BUS_READY_CYC - 1))        // [RULE_14]
                  st_nxt = S_IDLE;
            end
            S_IDLE: begin
               if (start_p) begin
                  err_nxt = 1'b0;
                  issue(1'b0, pll_seq_pkg::FREQ_RST_ADDR, 8'h00);
                  st_nxt = S_FR_RD;
               end else if (pll_go_p && init_done_r) begin // [RULE_17]
                  err_nxt      = 1'b0;
                  cnt_nxt      = 32'h0;
                  clk_seen_nxt = 1'b0;
                  st_nxt       = S_CLK_WAIT;
               end else if (uwr_p || urd_p) begin
                  issue(uwr_p, user_r[15:8], user_r[7:0]);
                  st_nxt = S_USER;
               end
            end
            S_FR_RD: if (!req_r) begin
               issue(1'b1, pll_seq_pkg::FREQ_RST_ADDR,
                     rd_r & ~(8'h01 << pll_seq_pkg::FREQ_RST_BIT)); // [RULE_04]
               st_nxt = S_FR_WR;
            end
            S_FR_WR: if (!req_r) begin
               issue(1'b1, pll_seq_pkg::GLITCH_ADDR,
                     pll_seq_pkg::GLITCH_VAL);             // [RULE_05]
               st_nxt = S_GL_WR;
            end
            S_GL_WR: if (!req_r) begin
               issue(1'b0, pll_seq_pkg::BLANK_ADDR, 8'h00);
               st_nxt = S_BK_RD;
            end
            S_BK_RD: if (!req_r) begin
               issue(1'b1, pll_seq_pkg::BLANK_ADDR,
                     rd_r | (8'h01 << pll_seq_pkg::BLANK_BIT)); // [RULE_06]
               st_nxt = S_BK_WR;
            end
            S_BK_WR: if (!req_r) begin
               init_done_nxt = !err_r;
               vid_nxt       = !err_r;                     // [RULE_10]
               st_nxt        = err_r ? S_ERR : S_IDLE;
            end
            S_CLK_WAIT: begin
               // a clock dropout restarts the stability window
               cnt_nxt = tmds_ok ? cnt_r + 32'h1 : 32'h0;
               if (tmds_ok && cnt_r >= 32'(CLK_STABLE_CYC - 1)) begin // [RULE_07] [RULE_16]
                  clk_seen_nxt = 1'b1;
                  step_nxt     = 3'd0;
                  issue(1'b1, op_first[15:8], op_first[7:0]);
                  st_nxt = S_PLL_STEP;
               end
            end
            S_PLL_STEP: if (!req_r) begin
               if (step_r == 3'd7) begin                   // [RULE_08] [RULE_09]
                  pll_done_nxt = !err_r;
                  st_nxt       = err_r ? S_ERR : S_IDLE;
               end else begin
                  step_nxt = step_r + 3'd1;
                  issue(1'b1, op_next[15:8], op_next[7:0]);
               end
            end
            S_USER: if (!req_r)
               st_nxt = S_IDLE;
            S_ERR: if (start_p) begin
               err_nxt = 1'b0;
               issue(1'b0, pll_seq_pkg::FREQ_RST_ADDR, 8'h00);
               st_nxt = S_FR_RD;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r        <= S_OFF;
         cnt_r       <= 32'h0;
         step_r      <= 3'd0;
         req_r       <= 1'b0;
         wr_r        <= 1'b0;
         addr_r      <= 8'h00;
         wdata_r     <= 8'h00;
         rd_r        <= 8'h00;
         pin_r       <= 1'b0;
         vid_r       <= 1'b0;
         init_done_r <= 1'b0;
         pll_done_r  <= 1'b0;
         err_r       <= 1'b0;
         clk_seen_r  <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         step_r      <= step_nxt;
         req_r       <= req_nxt;
         wr_r        <= wr_nxt;
         addr_r      <= addr_nxt;
         wdata_r     <= wdata_nxt;
         rd_r        <= rd_nxt;
         pin_r       <= pin_nxt;
         vid_r       <= vid_nxt;
         init_done_r <= init_done_nxt;
         pll_done_r  <= pll_done_nxt;
         err_r       <= err_nxt;
         clk_seen_r  <= clk_seen_nxt;
      end
   end

   // request and video enable held low until the pin rises; address, data and write keep last values
   assign power_down_bar_pin = pin_r;
   assign video_input_enable = vid_r;
   assign cfg_req            = req_r;
   assign cfg_write          = wr_r;
   assign cfg_addr           = addr_r;
   assign cfg_wdata          = wdata_r;

   // ------------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------------
   logic        wr_acc;
   logic        rd_acc;
   logic        mapped;
   logic [31:0] prdata_r, prdata_nxt;

   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && !penable && !pwrite;
   assign mapped  = paddr == pll_seq_pkg::REG_CTRL
                 || paddr == pll_seq_pkg::REG_STATUS
                 || paddr == pll_seq_pkg::REG_USER
                 || paddr == pll_seq_pkg::REG_RDDATA;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_r;

   assign start_p  = wr_acc && paddr == pll_seq_pkg::REG_CTRL
                     && pwdata[pll_seq_pkg::CTRL_START];
   assign pll_go_p = wr_acc && paddr == pll_seq_pkg::REG_CTRL
                     && pwdata[pll_seq_pkg::CTRL_PLL_GO];
   assign hard_p   = wr_acc && paddr == pll_seq_pkg::REG_CTRL
                     && pwdata[pll_seq_pkg::CTRL_HARD_RESET];
   assign uwr_p    = wr_acc && paddr == pll_seq_pkg::REG_CTRL
                     && pwdata[pll_seq_pkg::CTRL_USER_WR];
   assign urd_p    = wr_acc && paddr == pll_seq_pkg::REG_CTRL
                     && pwdata[pll_seq_pkg::CTRL_USER_RD];

   always_comb begin
      user_nxt   = user_r;
      prdata_nxt = prdata_r;
      if (wr_acc && paddr == pll_seq_pkg::REG_USER)
         user_nxt = pwdata[15:0];
      if (rd_acc) begin
         unique case (paddr)
            pll_seq_pkg::REG_STATUS:
               prdata_nxt = {25'h0, vid_r, clk_seen_r, err_r, pin_r,
                             pll_done_r, init_done_r, st_r != S_IDLE};
            pll_seq_pkg::REG_USER:   prdata_nxt = {16'h0, user_r};
            pll_seq_pkg::REG_RDDATA: prdata_nxt = {24'h0, rd_r};
            default:                 prdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_r   <= 16'h0000;
         prdata_r <= 32'h0;
      end else begin
         user_r   <= user_nxt;
         prdata_r <= prdata_nxt;
      end
   end
endmodule

// File: pll_seq_asserts.sv
// checker: power-up, init and pll reset order at the controller ports
`timescale 1ns/1ns
module pll_seq_asserts #(
   parameter int BUS_READY_CYC  = 20,
   parameter int HARD_RESET_CYC = 20,
   parameter int CLK_STABLE_CYC = 4
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       supplies_good,
   input wire logic       tmds_clk_ok,
   input wire logic       power_down_bar_pin,
   input wire logic       video_input_enable,
   input wire logic       cfg_req,
   input wire logic       cfg_write,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   input wire logic       cfg_ack,
   input wire logic       cfg_err
);
   // saturating run lengths: pin high, pin low, tmds good
   logic [17:0] hi_r, hi_nxt, lo_r, lo_nxt, ok_r, ok_nxt;
   logic [15:0] last_r, last_nxt;
   logic        wr;
   assign wr = cfg_req && cfg_write;
   always_comb begin
      hi_nxt = power_down_bar_pin ? hi_r + 18'(!(&hi_r)) : 18'h0;
      lo_nxt = power_down_bar_pin ? 18'h0 : lo_r + 18'(!(&lo_r));
      ok_nxt = tmds_clk_ok ? ok_r + 18'(!(&ok_r)) : 18'h0;
      // order of issued writes; a refused write still counts as issued
      last_nxt = (wr && cfg_ack) ? {cfg_addr, cfg_wdata} : last_r;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) {hi_r, lo_r, ok_r, last_r} <= '0;
      else {hi_r, lo_r, ok_r, last_r} <= {hi_nxt, lo_nxt, ok_nxt, last_nxt};
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pin_supply_a: assert property (
      $rose(power_down_bar_pin) |-> $past(supplies_good, 2))
      else $error("pin rose before supplies settled");
   bus_wait_a: assert property ($rose(cfg_req) |-> hi_r >= BUS_READY_CYC)
      else $error("device access too soon after pin rise");
   hard_low_a: assert property (
      $rose(power_down_bar_pin) |-> lo_r >= HARD_RESET_CYC)
      else $error("pin low pulse too short");
   req_hold_a: assert property (cfg_req && !cfg_ack |=>
      cfg_req && $stable({cfg_write, cfg_addr, cfg_wdata}))
      else $error("device request changed before ack");
   rsv_zero_a: assert property (
      wr && cfg_addr == 8'h42 |-> cfg_wdata[3:0] == 4'h0)
      else $error("paged write with reserved bits set");
   init_order_a: assert property ($rose(cfg_req) && wr &&
      cfg_addr == 8'h16 |-> cfg_wdata == 8'h02 && last_r[15:8] == 8'h5B
      && !last_r[5]) else $error("glitch write out of order");
   blank_set_a: assert property (
      wr && cfg_addr == 8'h04 |-> cfg_wdata[4])
      else $error("blanking bit not set");
   clk_window_a: assert property ($rose(cfg_req) && wr &&
      cfg_addr == 8'h40 |-> ok_r >= CLK_STABLE_CYC && video_input_enable)
      else $error("pll reset before clock window or init");
   data_order_a: assert property ($rose(cfg_req) && wr &&
      cfg_addr == 8'h42 |-> last_r == (cfg_wdata[4] ? 16'h4149 : 16'h4210))
      else $error("paged data write out of order");
   link_after_a: assert property ($rose(cfg_req) && wr &&
      cfg_addr == 8'h40 && cfg_wdata == 8'h14 |-> last_r == 16'h4200)
      else $error("link page before video release");
   video_gate_a: assert property ($rose(video_input_enable) |->
      power_down_bar_pin && hi_r >= BUS_READY_CYC)
      else $error("video enabled before pin and bus wait");
endmodule
bind pll_reset_init_sequencer pll_seq_asserts #(
   .BUS_READY_CYC(BUS_READY_CYC), .HARD_RESET_CYC(HARD_RESET_CYC),
   .CLK_STABLE_CYC(CLK_STABLE_CYC)) pll_seq_asserts_i (.pclk(pclk),
   .presetn(presetn), .supplies_good(supplies_good),
   .tmds_clk_ok(tmds_clk_ok), .power_down_bar_pin(power_down_bar_pin),
   .video_input_enable(video_input_enable), .cfg_req(cfg_req),
   .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
   .cfg_ack(cfg_ack), .cfg_err(cfg_err));

// File: pll_dev_model.sv
// partner: behavioural device on the byte-wide configuration port
`timescale 1ns/1ns
module pll_dev_model (
   input  wire logic       pclk,
   input  wire logic       power_down_bar_pin,
   input  wire logic       cfg_req,
   input  wire logic       cfg_write,
   input  wire logic [7:0] cfg_addr,
   input  wire logic [7:0] cfg_wdata,
   input  wire logic [1:0] ack_dly,
   input  wire logic       err_inj,
   input  wire logic [7:0] init_5b,
   input  wire logic [7:0] init_04,
   output logic            cfg_ack,
   output logic            cfg_err,
   output logic [7:0]      cfg_rdata,
   output logic [1:0]      pll_seen
);
   logic [7:0] mem [256];
   logic [7:0] pg [2];  // 0 video-input, 1 serial-link pll control
   logic [1:0] cnt;
   logic       pi, hit;
   assign pi  = mem[8'h40] == 8'h14;
   // paged access only for the two pll pages at offset 0x49
   assign hit = cfg_addr == 8'h42 && mem[8'h41] == 8'h49
      && (pi || mem[8'h40] == 8'h10);
   always @(posedge pclk or negedge power_down_bar_pin) begin
      if (!power_down_bar_pin) begin
         foreach (mem[k]) mem[k] <= 8'h00;
         mem[8'h5B] <= init_5b;
         mem[8'h04] <= init_04;
         pg <= '{8'h00, 8'h00};
         {pll_seen, cnt, cfg_ack, cfg_err, cfg_rdata} <= '0;
      end else if (cfg_req && !cfg_ack && cnt >= ack_dly) begin
         {cfg_ack, cfg_err, cnt} <= {1'b1, err_inj, 2'b00};
         cfg_rdata <= hit ? pg[pi] : mem[cfg_addr];
         if (cfg_write && !err_inj) mem[cfg_addr] <= cfg_wdata;
         if (cfg_write && !err_inj && hit) begin
            pg[pi] <= cfg_wdata & 8'h10;
            if (pg[pi][4] && !cfg_wdata[4]) pll_seen[pi] <= 1'b1;
         end
      end else begin
         {cfg_ack, cfg_err} <= 2'b00;
         cfg_rdata <= ~cfg_rdata;  // released line: no stale byte
         if (cfg_req && !cfg_ack) cnt <= cnt + 2'd1;
      end
   end
endmodule

// File: pll_reset_init_sequencer_bench.sv
// testbench: power-up, init, pll reset, user access, error, hard reset
`timescale 1ns/1ns
module pll_reset_init_sequencer_bench;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} exp_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, tag;
   logic        supplies_good, tmds_clk_ok, power_down_bar_pin, err_inj;
   logic        video_input_enable, cfg_req, cfg_write, cfg_ack, cfg_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata, v5b, v04;
   logic [1:0]  ack_dly, pll_seen;
   exp_s        rq[$];
   logic [15:0] wq[$];
   int          n_errors, checked, seed, cyc;

   pll_reset_init_sequencer #(.BUS_READY_CYC(20), .HARD_RESET_CYC(20),
      .CLK_STABLE_CYC(4)) pll_reset_init_sequencer_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .supplies_good(supplies_good),
      .tmds_clk_ok(tmds_clk_ok), .power_down_bar_pin(power_down_bar_pin),
      .video_input_enable(video_input_enable), .cfg_req(cfg_req),
      .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata));
   pll_dev_model pll_dev_model_i (.pclk(pclk),
      .power_down_bar_pin(power_down_bar_pin), .cfg_req(cfg_req),
      .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .ack_dly(ack_dly), .err_inj(err_inj), .init_5b(v5b), .init_04(v04),
      .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata),
      .pll_seen(pll_seen));

   task results;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; a noted read queues its expectation first
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic n, input logic [31:0] m, input logic e);
      if (n) rq.push_back('{d, m, e});
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata, tag} <= {1'b1, w, a, d, n};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      {psel, penable, tag} <= 3'b000;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      apb(1'b0, a, d, 1'b1, m, a > 12'h00C);
   endtask
   task poll(input int b, input logic v);
      int i;
      r = {32{~v}};
      for (i = 0; i < 400 && r[b] !== v; i++)
         apb(1'b0, pll_seq_pkg::REG_STATUS, 32'h0, 1'b0, 32'h0, 1'b0);
      if (r[b] !== v) begin
         n_errors++;
         results();
      end
   endtask
   task dev(input logic [15:0] u, input logic [31:0] c);
      wr(pll_seq_pkg::REG_USER, {16'h0, u});
      wr(pll_seq_pkg::REG_CTRL, c);
      poll(0, 1'b0);
   endtask

   always @(posedge pclk) begin
      exp_s x;
      if (psel && penable && pready && !pwrite && tag) begin
         x = rq.pop_front();
         chk(prdata & x.m, x.d & x.m);
         chk(32'(pslverr), 32'(x.e));
      end
      // any device write with nothing queued is unexpected
      if (cfg_req && cfg_ack && cfg_write)
         chk({cfg_addr, cfg_wdata}, wq.size() ? wq.pop_front() : 32'hFFFFFFFF);
   end
   always @(posedge pclk) begin
      ack_dly <= 2'($random(seed));
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      {seed, n_errors, checked, cyc} = {33, 0, 0, 0};
      {presetn, psel, penable, pwrite, tag, paddr, pwdata} = '0;
      {supplies_good, tmds_clk_ok, err_inj, ack_dly} = '0;
      v5b = 8'($random(seed)) | 8'h20;
      v04 = 8'($random(seed)) & 8'hEF;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(pll_seq_pkg::REG_STATUS, 32'h1, 32'hFFFFFFFF);
      repeat (30) @(posedge pclk);
      supplies_good <= 1'b1;
      poll(0, 1'b0);
      rd(pll_seq_pkg::REG_STATUS, 32'h8, 32'hFFFFFFFF);
      wr(pll_seq_pkg::REG_CTRL, 32'h2);
      repeat (20) @(posedge pclk);
      rd(pll_seq_pkg::REG_STATUS, 32'h8, 32'hFFFFFFFF);
      wq = '{{8'h5B, v5b & 8'hDF}, 16'h1602, {8'h04, v04 | 8'h10}};
      dev(16'h0, 32'h1);
      rd(pll_seq_pkg::REG_STATUS, 32'h4A, 32'hFFFFFFFF);
      wr(pll_seq_pkg::REG_CTRL, 32'h2);
      repeat (40) @(posedge pclk);
      tmds_clk_ok <= 1'b1;
      wq = '{16'h4010, 16'h4149, 16'h4210, 16'h4200,
             16'h4014, 16'h4149, 16'h4210, 16'h4200};
      poll(0, 1'b0);
      rd(pll_seq_pkg::REG_STATUS, 32'h6E, 32'hFFFFFFFF);
      chk(32'(pll_seen), 32'h3);
      chk(32'({power_down_bar_pin, video_input_enable}), 32'h3);
      dev(16'h5B00, 32'h10);
      rd(pll_seq_pkg::REG_RDDATA, {24'h0, v5b & 8'hDF}, 32'hFF);
      dev(16'h1600, 32'h10);
      rd(pll_seq_pkg::REG_RDDATA, 32'h2, 32'hFF);
      dev(16'h0400, 32'h10);
      rd(pll_seq_pkg::REG_RDDATA, {24'h0, v04 | 8'h10}, 32'hFF);
      dev(16'h4200, 32'h10);
      rd(pll_seq_pkg::REG_RDDATA, 32'h0, 32'hFF);
      wq = '{16'h3A55};
      dev(16'h3A55, 32'h8);
      rd(pll_seq_pkg::REG_CTRL, 32'h0, 32'hFFFFFFFF);
      rd(12'h010, 32'h0, 32'hFFFFFFFF);
      err_inj <= 1'b1;
      wq = '{{8'h5B, v5b & 8'hDF}, 16'h1602, {8'h04, v04 | 8'h10}};
      wr(pll_seq_pkg::REG_CTRL, 32'h1);
      poll(1, 1'b0);
      rd(pll_seq_pkg::REG_STATUS, 32'h11, 32'h13);
      err_inj <= 1'b0;
      wq = '{{8'h5B, v5b & 8'hDF}, 16'h1602, {8'h04, v04 | 8'h10}};
      dev(16'h0, 32'h1);
      rd(pll_seq_pkg::REG_STATUS, 32'h02, 32'h13);
      wr(pll_seq_pkg::REG_CTRL, 32'h4);
      poll(3, 1'b0);
      poll(3, 1'b1);
      poll(0, 1'b0);
      rd(pll_seq_pkg::REG_STATUS, 32'h08, 32'h49);
      chk(32'({power_down_bar_pin, video_input_enable}), 32'h2);
      chk(32'(wq.size()), 32'h0);
      results();
   end
endmodule
